// ### src/ocs_regs.vh
// constant set for the oscillator control block: offsets, fields, resets
// assumes a 32-bit AHB-Lite register bus and a 20 MHz bus clock
`ifndef OCS_REGS_VH
`define OCS_REGS_VH

`define OCS_ADDR_W 4
`define OCS_OFF_CTRL 4'h0
`define OCS_OFF_IRQ_STAT 4'h4
`define OCS_OFF_IRQ_CLR 4'h8
`define OCS_OFF_IRQ_EN 4'hC

`define OCS_BIT_SEL 0
`define OCS_BIT_SLOW_OK 1
`define OCS_BIT_FAST_OK 2
`define OCS_BIT_TIMEOUT 3
`define OCS_FREQ_LSB 4
`define OCS_FREQ_MSB 6

`define OCS_FREQ_RST 3'b110
`define OCS_FREQ_SLOW 3'b000
`define OCS_FREQ_FAST_MAX 3'b111

// interrupt status bits
`define OCS_IRQ_W 3
`define OCS_IRQ_FAST 0
`define OCS_IRQ_SLOW 1
`define OCS_IRQ_TIMEOUT 2

// clock mode field of config word one
`define OCS_MODE_LP 3'b000
`define OCS_MODE_XT 3'b001
`define OCS_MODE_HS 3'b010
`define OCS_MODE_EC 3'b011
`define OCS_MODE_INTIO 3'b100
`define OCS_MODE_INT 3'b101
`define OCS_MODE_RCIO 3'b110
`define OCS_MODE_RC 3'b111

`define OCS_OST_CYCLES 1024

`endif

// ### src/ocs_sync3.v
// three-flop synchroniser bank for pin inputs of another domain
// assumes the output only moves once stages two and three agree
`timescale 1ns/10ps
module ocs_sync3 #(
   parameter W = 1
) (
   input wire hclk,
   input wire hresetn,
   input wire [W-1:0] pin_in,
   output wire [W-1:0] level_out
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg lvl_r;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               lvl_r <= 1'b0;
            end else begin
               s1_r <= pin_in[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               // s1 is read by s2 only; filter looks at stages two and three
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign level_out[i] = lvl_r;
      end
   endgenerate
endmodule // ocs_sync3

// ### src/ocs_ost_cnt.v
// oscillator start-up counter: counts edges of the crystal clock
// assumes osc_edge is a one-cycle pulse per oscillator cycle
`timescale 1ns/10ps
`include "ocs_regs.vh"
module ocs_ost_cnt #(
   parameter CYCLES = `OCS_OST_CYCLES
) (
   input wire hclk,
   input wire hresetn,
   input wire restart,
   input wire osc_edge,
   output reg done_r
);
   reg [11:0] cnt_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 12'h000;
         done_r <= 1'b0;
      end else if (restart) begin
         cnt_r <= 12'h000;
         done_r <= 1'b0;
      end else if (osc_edge && !done_r) begin
         // release on the last of the counted oscillator cycles
         if (cnt_r == CYCLES[11:0] - 12'h001) begin
            done_r <= 1'b1;
         end
         cnt_r <= cnt_r + 12'h001;
      end
   end
endmodule // ocs_ost_cnt

// ### src/ocs_osc_ctrl.v
// oscillator control and select block with AHB-Lite register slave
// assumes straps are static after reset and oscillator pins are async
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`include "ocs_regs.vh"
module ocs_osc_ctrl #(
   parameter OST_CYCLES = `OCS_OST_CYCLES
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire [2:0] clk_mode_strap,
   input wire two_speed_strap,
   input wire fail_safe_strap,
   input wire fast_osc_ok_pin,
   input wire slow_osc_ok_pin,
   input wire ext_osc_pin,
   input wire wake_up,
   output reg sys_clk_select_o,
   output reg use_internal_o,
   output reg use_slow_osc_o,
   output reg [2:0] fast_div_log2_o,
   output reg [2:0] clk_mode_o,
   output reg ost_enable_o,
   output reg exec_run_o,
   output reg irq
);
   // bus capture
   reg wr_pend_r;
   reg [`OCS_ADDR_W-1:0] wr_addr_r;
   wire acc = hsel & hready & htrans[1];
   wire [`OCS_ADDR_W-1:0] a_off = haddr[`OCS_ADDR_W-1:0];

   // control state
   reg [2:0] freq_r;
   reg sel_r;
   reg [2:0] mode_r;
   reg two_speed_r;
   reg fail_safe_r;
   reg strap_ok_r;
   reg timeout_r;
   reg [`OCS_IRQ_W-1:0] irq_stat_r;
   reg [`OCS_IRQ_W-1:0] irq_en_r;
   reg fast_d_r;
   reg slow_d_r;
   reg timeout_d_r;
   reg osc_d_r;

   wire [2:0] pin_lvl;
   wire fast_ok = pin_lvl[0];
   wire slow_ok = pin_lvl[1];
   wire osc_lvl = pin_lvl[2];
   wire ost_done;

   // crystal modes of the three gains
   wire crystal = (mode_r == `OCS_MODE_LP) | (mode_r == `OCS_MODE_XT) |
      (mode_r == `OCS_MODE_HS);
   wire int_mode = (mode_r == `OCS_MODE_INTIO) |
      (mode_r == `OCS_MODE_INT);
   // timeout bit stays low until start-up only for these cases
   wire slow_case = (two_speed_r & crystal) | fail_safe_r;
   wire ext_ready = ~crystal | ost_done;
   wire ost_restart = ~strap_ok_r | wake_up;

   ocs_sync3 #(
      .W(3)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in({ext_osc_pin, slow_osc_ok_pin, fast_osc_ok_pin}),
      .level_out(pin_lvl)
   );

   ocs_ost_cnt #(
      .CYCLES(OST_CYCLES)
   ) u_ost (
      .hclk(hclk),
      .hresetn(hresetn),
      .restart(ost_restart),
      .osc_edge(osc_lvl & ~osc_d_r & crystal),
      .done_r(ost_done)
   );

   wire [7:0] ctrl_rd = {1'b0, freq_r, timeout_r, fast_ok, slow_ok,
      sel_r};

   reg [31:0] rd_mux;
   always @* begin
      case (a_off)
         `OCS_OFF_CTRL: rd_mux = {24'h00_0000, ctrl_rd};
         `OCS_OFF_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_r};
         `OCS_OFF_IRQ_EN: rd_mux = {29'h0000_0000, irq_en_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   wire wr_ctrl = wr_pend_r & (wr_addr_r == `OCS_OFF_CTRL);
   wire wr_clr = wr_pend_r & (wr_addr_r == `OCS_OFF_IRQ_CLR);
   wire wr_en = wr_pend_r & (wr_addr_r == `OCS_OFF_IRQ_EN);

   // zero wait states: read data registered at the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 4'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= acc & hwrite;
         if (acc) begin
            wr_addr_r <= a_off;
         end
         if (acc && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // straps are caught after reset release, never under reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_ok_r <= 1'b0;
         mode_r <= `OCS_MODE_LP;
         two_speed_r <= 1'b0;
         fail_safe_r <= 1'b0;
      end else if (!strap_ok_r) begin
         strap_ok_r <= 1'b1;
         mode_r <= clk_mode_strap;
         two_speed_r <= two_speed_strap;
         fail_safe_r <= fail_safe_strap;
      end
   end

   // only select and frequency bits take writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         freq_r <= `OCS_FREQ_RST;
         sel_r <= 1'b0;
      end else if (wr_ctrl) begin
         freq_r <= hwdata[`OCS_FREQ_MSB:`OCS_FREQ_LSB];
         sel_r <= hwdata[`OCS_BIT_SEL];
      end
   end

   // timeout bit: 1 while running from the mode-field clock
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timeout_r <= 1'b1;
      end else if (!strap_ok_r) begin
         timeout_r <= ~((two_speed_strap &
            (clk_mode_strap == `OCS_MODE_LP |
            clk_mode_strap == `OCS_MODE_XT |
            clk_mode_strap == `OCS_MODE_HS)) | fail_safe_strap);
      end else begin
         timeout_r <= ~sel_r & (ext_ready | ~slow_case);
      end
   end

   // interrupt events: set wins over a clear in the same cycle
   wire [`OCS_IRQ_W-1:0] ev = {timeout_r & ~timeout_d_r,
      slow_ok & ~slow_d_r, fast_ok & ~fast_d_r};
   wire [`OCS_IRQ_W-1:0] clr = wr_clr ? hwdata[`OCS_IRQ_W-1:0] :
      {`OCS_IRQ_W{1'b0}};
   wire [`OCS_IRQ_W-1:0] stat_nxt = (irq_stat_r & ~clr) | ev;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= {`OCS_IRQ_W{1'b0}};
         irq_en_r <= {`OCS_IRQ_W{1'b0}};
         fast_d_r <= 1'b0;
         slow_d_r <= 1'b0;
         timeout_d_r <= 1'b1;
         osc_d_r <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq_stat_r <= stat_nxt;
         if (wr_en) begin
            irq_en_r <= hwdata[`OCS_IRQ_W-1:0];
         end
         fast_d_r <= fast_ok;
         slow_d_r <= slow_ok;
         timeout_d_r <= timeout_r | ~strap_ok_r;
         osc_d_r <= osc_lvl;
         irq <= |(stat_nxt & (wr_en ? hwdata[`OCS_IRQ_W-1:0] : irq_en_r));
      end
   end

   // clock routing outputs
   reg [2:0] div_nxt;
   always @* begin
      // 111 divides by 1 ... 001 by 64; 000 takes the slow oscillator
      case (freq_r)
         `OCS_FREQ_SLOW: div_nxt = 3'b000;
         default: div_nxt = `OCS_FREQ_FAST_MAX - freq_r;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_clk_select_o <= 1'b0;
         use_internal_o <= 1'b0;
         use_slow_osc_o <= 1'b0;
         fast_div_log2_o <= 3'b001;
         clk_mode_o <= `OCS_MODE_LP;
         ost_enable_o <= 1'b0;
         exec_run_o <= 1'b0;
      end else begin
         sys_clk_select_o <= sel_r;
         // internal clock when selected, mode says so, or crystal start-up wait under two-speed or fail-safe
         use_internal_o <= sel_r | int_mode |
            (strap_ok_r & slow_case & ~ext_ready);
         use_slow_osc_o <= (freq_r == `OCS_FREQ_SLOW);
         fast_div_log2_o <= div_nxt;
         clk_mode_o <= mode_r;
         ost_enable_o <= crystal & ~ost_done;
         exec_run_o <= strap_ok_r & ~wake_up &
            (ext_ready | two_speed_r | fail_safe_r | sel_r);
      end
   end
endmodule // ocs_osc_ctrl

// ### verification/ocs_osc_model.sv
// pin model: oscillator stable flags and a slow crystal wave
// assumes the bus clock and bench-set enables
`timescale 1ns/10ps
module ocs_osc_model (
   input wire hclk,
   input wire fast_en,
   input wire slow_en,
   output reg fast_ok,
   output reg slow_ok,
   output reg xtal
);
   reg [2:0] ph_r;
   initial begin
      ph_r = 3'h0;
      fast_ok = 1'b0;
      slow_ok = 1'b0;
      xtal = 1'b0;
   end
   always @(posedge hclk) begin
      fast_ok <= fast_en;
      slow_ok <= slow_en;
      ph_r <= (ph_r == 3'h4) ? 3'h0 : ph_r + 3'h1;
      // period of 10 clocks keeps the wave under hclk/8
      if (ph_r == 3'h4) xtal <= ~xtal;
   end
endmodule // ocs_osc_model

// ### verification/ocs_osc_ctrl_assertions.sv
// port checker for the oscillator control block
// assumes hready is tied to hreadyout
`timescale 1ns/10ps
module ocs_osc_ctrl_assertions (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire sys_clk_select_o,
   input wire use_internal_o,
   input wire use_slow_osc_o,
   input wire [2:0] fast_div_log2_o,
   input wire [2:0] clk_mode_o,
   input wire ost_enable_o
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_ctrl;
      hsel && hready && htrans[1] && haddr[3:0] == 4'h0;
   endsequence
   sequence s_wr;
      (s_ctrl and hwrite) ##1 1'b1;
   endsequence
   a_slow_div: assert property (use_slow_osc_o |-> !fast_div_log2_o)
      else $error("slow osc with divider");
   a_div_range: assert property (fast_div_log2_o != 3'h7)
      else $error("divider out of range");
   a_sel_int: assert property (sys_clk_select_o [*2] |-> use_internal_o)
      else $error("select without internal clock");
   a_mode_int: assert property ((clk_mode_o[2:1] == 2'b10 &&
      $stable(clk_mode_o)) |=> use_internal_o)
      else $error("internal mode not used");
   a_wr_set: assert property (s_wr ##0 hwdata[0] |->
      ##[1:3] sys_clk_select_o) else $error("select not set");
   a_wr_clr: assert property (s_wr ##0 !hwdata[0] |->
      ##[1:3] !sys_clk_select_o) else $error("select not cleared");
   a_rd_top: assert property ((s_ctrl and !hwrite) |=>
      hrdata[31:7] == 25'h000_0000) else $error("top bits not zero");
   a_ost_hold: assert property ($rose(ost_enable_o) |->
      ost_enable_o [*8]) else $error("start-up count too short");
endmodule // ocs_osc_ctrl_assertions
bind ocs_osc_ctrl ocs_osc_ctrl_assertions u_chk (.*);

// ### verification/ocs_osc_ctrl_tb.sv
// testbench: AHB-Lite register tests of the oscillator control block
// assumes a shortened start-up count and zero-wait transfers
`timescale 1ns/10ps
module ocs_osc_ctrl_tb;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg ts = 1'b0;
   reg fs = 1'b0;
   reg wk = 1'b0;
   reg fen = 1'b1;
   reg sen = 1'b1;
   reg [1:0] htrans = 2'h0;
   reg [2:0] mode = 3'h0;
   reg [31:0] haddr = 32'h0000_0000;
   reg [31:0] hwdata = 32'h0000_0000;
   reg [31:0] rd;
   reg [31:0] r1;
   wire hready, hresp, fok, sok, xt, sel, uint, uslow, ost, run, irq;
   wire [31:0] hrdata;
   wire [2:0] div;
   wire [2:0] cmode;
   integer fail_count = 0;
   integer num_checks = 0;
   integer i;
   always #25 hclk = ~hclk;
   ocs_osc_model u_osc (.hclk(hclk), .fast_en(fen), .slow_en(sen),
      .fast_ok(fok), .slow_ok(sok), .xtal(xt));
   ocs_osc_ctrl #(.OST_CYCLES(8)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .clk_mode_strap(mode), .two_speed_strap(ts), .fail_safe_strap(fs),
      .fast_osc_ok_pin(fok), .slow_osc_ok_pin(sok), .ext_osc_pin(xt),
      .wake_up(wk), .sys_clk_select_o(sel), .use_internal_o(uint),
      .use_slow_osc_o(uslow), .fast_div_log2_o(div), .clk_mode_o(cmode),
      .ost_enable_o(ost), .exec_run_o(run), .irq(irq));
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask
   // a write leaves one spare edge so its effects are visible
   task xfer(input w, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= a;
         @(posedge hclk);
         while (hready !== 1'b1) @(posedge hclk);
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge hclk);
         while (hready !== 1'b1) @(posedge hclk);
         rd = hrdata;
         if (w) @(posedge hclk);
      end
   endtask
   task rst(input [2:0] m, input t, input f);
      begin
         hresetn <= 1'b0;
         mode <= m;
         ts <= t;
         fs <= f;
         repeat (6) @(posedge hclk);
         hresetn <= 1'b1;
         @(posedge hclk);
         // status pins need three flops and a filter edge after release
         repeat (4) @(posedge hclk);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count = fail_count + 1;
      tally_and_finish;
   end
   initial begin
      rst(3'h0, 1'b0, 1'b0);
      xfer(0, 0, 0);
      chk(rd, 32'h0000_006e);
      chk({ost, run}, 2'h2);
      chk(hresp, 1'b0);
      repeat (60) @(posedge hclk);
      chk(run, 1'b0);
      repeat (40) @(posedge hclk);
      chk(run, 1'b1);
      wk <= 1'b1;
      @(posedge hclk);
      wk <= 1'b0;
      repeat (4) @(posedge hclk);
      chk(ost, 1'b1);
      $display("test start-up done");
      for (i = 0; i < 4; i = i + 1) begin
         rst((i < 3) ? i : 2, i < 3, i == 3);
         xfer(0, 0, 0);
         chk(rd, 32'h0000_0066);
      end
      repeat (120) @(posedge hclk);
      xfer(0, 0, 0);
      chk(rd[3], 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
         rst(i, 1'b0, 1'b0);
         repeat (4) @(posedge hclk);
         chk({cmode, uint}, {i[2:0], i == 4 || i == 5});
         chk(ost, i < 3);
      end
      $display("test modes done");
      for (i = 0; i < 8; i = i + 1) begin
         xfer(1, 0, i << 4);
         xfer(0, 0, 0);
         chk(rd[6:4], i);
         chk({div, uslow}, (i == 0) ? 1 : (7 - i) * 2);
      end
      xfer(1, 0, 32'h0000_0061);
      xfer(0, 0, 0);
      chk({sel, uint, rd[3]}, 3'h6);
      xfer(1, 0, 32'h0000_0060);
      xfer(0, 0, 0);
      chk({sel, uint, rd[3]}, 3'h1);
      r1 = rd;
      xfer(1, 0, {24'hff_ffff, 4'hf, ~r1[3:1], 1'b0});
      xfer(0, 0, 0);
      chk(rd[31:1], {25'h000_0000, 3'h7, r1[3:1]});
      $display("test control done");
      xfer(1, 8, 32'h0000_0007);
      xfer(1, 12, 32'h0000_0001);
      fen <= 1'b0;
      sen <= 1'b0;
      repeat (6) @(posedge hclk);
      xfer(0, 0, 0);
      chk(rd[2:1], 2'h0);
      xfer(1, 8, 32'h0000_0007);
      xfer(0, 4, 0);
      chk({irq, rd[2:0]}, 4'h0);
      fen <= 1'b1;
      sen <= 1'b1;
      repeat (6) @(posedge hclk);
      xfer(0, 0, 0);
      chk(rd[2:1], 2'h3);
      xfer(0, 4, 0);
      chk({irq, rd[2:0]}, 4'hb);
      xfer(1, 12, 32'h0000_0000);
      xfer(0, 0, 0);
      chk(irq, 1'b0);
      xfer(1, 12, 32'h0000_0002);
      xfer(1, 8, 32'h0000_0002);
      xfer(0, 4, 0);
      chk({irq, rd[2:0]}, 4'h1);
      $display("test interrupts done");
      tally_and_finish;
   end
endmodule // ocs_osc_ctrl_tb
